/* File: design/mcf_accum_filter.sv */
// accumulation-mode filter for one energy kind, total and fundamental paths
`timescale 1ns/1ns
module mcf_accum_filter #(
   parameter int PW       = 32,
   parameter bit REACTIVE = 1'b0
) (
   // clock, reset, enable
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  wire logic                ce,
   // live configuration
   mcf_cfg_if.user                  cfg,
   // power samples
   input  wire logic signed [PW-1:0] total_in,
   input  wire logic signed [PW-1:0] fund_in,
   // samples as they go on to energy and pulse logic
   output logic signed [PW:0]       total_out,
   output logic signed [PW:0]       fund_out
);
   import mcf_pkg::*;

   mcf_accum_e mode; // mode for this energy kind
   assign mode = REACTIVE ? cfg.reactive_accum_mode : cfg.active_accum_mode;

   // one extra bit so the magnitude of the most negative sample fits
   function automatic logic signed [PW:0] apply_mode(input mcf_accum_e m, input logic signed [PW-1:0] x);
      logic signed [PW:0] w;
      w = (PW+1)'(x);
      case (m)
         MCF_ACC_ABS: apply_mode = w[PW] ? -w : w;
         MCF_ACC_POS: apply_mode = w[PW] ? '0 : w;
         MCF_ACC_NEG: apply_mode = w[PW] ? w : '0;
         default:     apply_mode = w;
      endcase
   endfunction

   wire signed [PW:0] next_total = apply_mode(mode, total_in);
   wire signed [PW:0] next_fund  = apply_mode(mode, fund_in);

   // output stage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         total_out <= '0;
         fund_out  <= '0;
      end else if (ce) begin
         total_out <= next_total;
         fund_out  <= next_fund;
      end
   end

   a_abs_nonneg: assert property (@(posedge clk) disable iff (!rst_n)
      ce && mode == MCF_ACC_ABS |=> !total_out[PW] && !fund_out[PW] && (total_out != 0 || $past(total_in) == 0))
      else $error("absolute mode produced a negative or lost sample");
   a_signed_pass: assert property (@(posedge clk) disable iff (!rst_n)
      ce && mode == MCF_ACC_SIGNED |=> total_out == $past(total_in) && fund_out == $past(fund_in))
      else $error("signed mode altered a sample");
   a_pos_only: assert property (@(posedge clk) disable iff (!rst_n)
      ce && mode == MCF_ACC_POS && total_in[PW-1] |=> total_out == 0)
      else $error("positive mode passed a negative sample");
   a_neg_only: assert property (@(posedge clk) disable iff (!rst_n)
      ce && mode == MCF_ACC_NEG && !fund_in[PW-1] |=> fund_out == 0)
      else $error("negative mode passed a positive sample");
endmodule

/* File: design/mcf_cfg_if.sv */
// interface carrying the live configuration from the register bank to the datapath
`timescale 1ns/1ns
interface mcf_cfg_if;
   import mcf_pkg::*;
   mcf_wiring_e wiring_config_sel;    // wiring arrangement
   mcf_accum_e  active_accum_mode;    // active energy mode
   mcf_accum_e  reactive_accum_mode;  // reactive energy mode
   // register bank drives, datapath listens
   modport ctrl (output wiring_config_sel, output active_accum_mode, output reactive_accum_mode);
   modport user (input wiring_config_sel, input active_accum_mode, input reactive_accum_mode);
endinterface

/* File: design/mcf_metering_config.sv */
// metering configuration register bank with wiring, accumulation, overcurrent and source routing
`timescale 1ns/1ns
module mcf_metering_config #(
   parameter int VW  = 24, // voltage sample width
   parameter int PW  = 32, // power sample width
   parameter int LPW = 32  // line period width
) (
   // clock, reset, enable
   input  wire logic                         clk,
   input  wire logic                         rst_n,
   input  wire logic                         ce,
   // register port
   input  wire logic [mcf_pkg::ADDR_W-1:0]   addr,
   input  wire logic [mcf_pkg::DATA_W-1:0]   wdata,
   input  wire logic                         wr_en,
   input  wire logic                         rd_en,
   output logic      [mcf_pkg::DATA_W-1:0]   rdata,
   // measured phase voltages
   input  wire logic signed [VW-1:0]         phase_a_voltage,
   input  wire logic signed [VW-1:0]         phase_b_voltage,
   input  wire logic signed [VW-1:0]         phase_c_voltage,
   // derived phase voltages
   output logic signed [VW+1:0]              phase_a_derived,
   output logic signed [VW+1:0]              phase_b_derived,
   output logic signed [VW+1:0]              phase_c_derived,
   // power samples in
   input  wire logic signed [PW-1:0]         active_total,
   input  wire logic signed [PW-1:0]         active_fund,
   input  wire logic signed [PW-1:0]         reactive_total,
   input  wire logic signed [PW-1:0]         reactive_fund,
   // power samples after accumulation mode
   output logic signed [PW:0]                active_total_acc,
   output logic signed [PW:0]                active_fund_acc,
   output logic signed [PW:0]                reactive_total_acc,
   output logic signed [PW:0]                reactive_fund_acc,
   // overcurrent: index 0..3 is phase a, b, c, neutral
   input  wire logic [mcf_pkg::OC_W-1:0]     overcurrent_raw,
   output logic      [mcf_pkg::OC_W-1:0]     overcurrent_flags,
   // peak detection enables: index 0..2 is phase a, b, c
   output logic      [mcf_pkg::PEAK_W-1:0]   peak_phase_sel,
   // line period measurements
   input  wire logic [LPW-1:0]               phase_a_line_period,
   input  wire logic [LPW-1:0]               phase_b_line_period,
   input  wire logic [LPW-1:0]               phase_c_line_period,
   input  wire logic [LPW-1:0]               combined_line_period,
   output logic      [LPW-1:0]               selected_line_period,
   // zero crossings
   input  wire logic                         phase_a_zero_cross,
   input  wire logic                         phase_b_zero_cross,
   input  wire logic                         phase_c_zero_cross,
   input  wire logic                         combined_zero_cross,
   output logic                              shared_pulse_zc_pin,
   output logic                              line_cycle_tick
);
   import mcf_pkg::*;

   // refuse widths the datapath cannot serve
   generate
      if (VW < 2 || PW < 2 || LPW < 1) begin : g_bad_width
         $error("mcf_metering_config: sample widths too small");
      end
   endgenerate

   // configuration fields; reserved bits have no storage at all
   logic [WIRING_W-1:0] wiring_config_sel;    // wiring arrangement code
   logic [ACCUM_W-1:0]  reactive_accum_mode;  // reactive accumulation code
   logic [ACCUM_W-1:0]  active_accum_mode;    // active accumulation code
   logic [OC_W-1:0]     overcurrent_enables;  // overcurrent channel enables
   logic [SRC_W-1:0]    line_period_src;      // line period source code
   logic [SRC_W-1:0]    zero_cross_src;       // zero-cross source code

   // address decode
   wire hit_acc    = addr == ACCUM_WIRING_OFS;
   wire hit_ocpk   = addr == OC_PEAK_OFS;
   wire hit_pzc    = addr == PERIOD_ZC_OFS;
   wire hit_status = addr == STATUS_OFS;
   wire hit_any    = hit_acc || hit_ocpk || hit_pzc || hit_status;

   // write qualifiers
   wire wr_acc  = ce && wr_en && hit_acc;
   wire wr_ocpk = ce && wr_en && hit_ocpk;
   wire wr_pzc  = ce && wr_en && hit_pzc;

   // read words assembled from fields; all other bit positions are zero
   wire [DATA_W-1:0] acc_word    = (DATA_W'(wiring_config_sel) << WIRING_LSB)
                                 | (DATA_W'(reactive_accum_mode) << REACT_LSB)
                                 | (DATA_W'(active_accum_mode) << ACTIVE_LSB);
   wire [DATA_W-1:0] ocpk_word   = (DATA_W'(overcurrent_enables) << OC_LSB)
                                 | (DATA_W'(peak_phase_sel) << PEAK_LSB);
   wire [DATA_W-1:0] pzc_word    = (DATA_W'(line_period_src) << LP_LSB)
                                 | (DATA_W'(zero_cross_src) << ZC_LSB);
   wire [DATA_W-1:0] status_word = (DATA_W'(overcurrent_flags) << STATUS_OC_LSB)
                                 | (DATA_W'(shared_pulse_zc_pin) << STATUS_ZC_BIT);

   // read mux; an unmapped address answers zero
   wire [DATA_W-1:0] next_rdata = !hit_any   ? '0 :
                                  hit_acc    ? acc_word :
                                  hit_ocpk   ? ocpk_word :
                                  hit_pzc    ? pzc_word :
                                  status_word;

   // wiring and accumulation fields
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wiring_config_sel   <= WIRING_RST;
         reactive_accum_mode <= ACCUM_RST;
         active_accum_mode   <= ACCUM_RST;
      end else if (wr_acc) begin
         wiring_config_sel   <= wdata[WIRING_LSB +: WIRING_W];
         reactive_accum_mode <= wdata[REACT_LSB +: ACCUM_W];
         active_accum_mode   <= wdata[ACTIVE_LSB +: ACCUM_W];
      end
   end

   // overcurrent and peak fields; enables come up all set
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         overcurrent_enables <= OVERCURRENT_ENABLES_RST;
         peak_phase_sel      <= PEAK_RST;
      end else if (wr_ocpk) begin
         overcurrent_enables <= wdata[OC_LSB +: OC_W];
         peak_phase_sel      <= wdata[PEAK_LSB +: PEAK_W];
      end
   end

   // source selection fields; both come up on the combined signal
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         line_period_src <= LP_RST;
         zero_cross_src  <= ZC_RST;
      end else if (wr_pzc) begin
         line_period_src <= wdata[LP_LSB +: SRC_W];
         zero_cross_src  <= wdata[ZC_LSB +: SRC_W];
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= '0;
      end else if (ce) begin
         rdata <= rd_en ? next_rdata : '0;
      end
   end

   // configuration to the datapath modules
   mcf_cfg_if cfg_bus ();
   assign cfg_bus.wiring_config_sel   = mcf_wiring_e'(wiring_config_sel);
   assign cfg_bus.active_accum_mode   = mcf_accum_e'(active_accum_mode);
   assign cfg_bus.reactive_accum_mode = mcf_accum_e'(reactive_accum_mode);

   // wiring arrangement voltage derivation
   mcf_wiring_map #(.VW(VW)) u_wiring (
      .clk    (clk),
      .rst_n  (rst_n),
      .ce     (ce),
      .cfg    (cfg_bus.user),
      .va     (phase_a_voltage),
      .vb     (phase_b_voltage),
      .vc     (phase_c_voltage),
      .va_out (phase_a_derived),
      .vb_out (phase_b_derived),
      .vc_out (phase_c_derived)
   );

   // active energy accumulation mode
   mcf_accum_filter #(.PW(PW), .REACTIVE(1'b0)) u_active (
      .clk       (clk),
      .rst_n     (rst_n),
      .ce        (ce),
      .cfg       (cfg_bus.user),
      .total_in  (active_total),
      .fund_in   (active_fund),
      .total_out (active_total_acc),
      .fund_out  (active_fund_acc)
   );

   // reactive energy accumulation mode
   mcf_accum_filter #(.PW(PW), .REACTIVE(1'b1)) u_reactive (
      .clk       (clk),
      .rst_n     (rst_n),
      .ce        (ce),
      .cfg       (cfg_bus.user),
      .total_in  (reactive_total),
      .fund_in   (reactive_fund),
      .total_out (reactive_total_acc),
      .fund_out  (reactive_fund_acc)
   );

   // source mux; code three picks the combined measurement
   function automatic logic [LPW-1:0] pick_period(input logic [SRC_W-1:0] s, input logic [LPW-1:0] a,
                                                  input logic [LPW-1:0] b, input logic [LPW-1:0] c,
                                                  input logic [LPW-1:0] m);
      case (s)
         2'h0:    pick_period = a;
         2'h1:    pick_period = b;
         2'h2:    pick_period = c;
         default: pick_period = m;
      endcase
   endfunction

   // zero crossings gathered so the same index order serves both selects
   wire [3:0] zc_vec = {combined_zero_cross, phase_c_zero_cross, phase_b_zero_cross, phase_a_zero_cross};

   // selected sources and gated overcurrent
   wire [LPW-1:0]  next_period = pick_period(line_period_src, phase_a_line_period, phase_b_line_period,
                                             phase_c_line_period, combined_line_period);
   wire            next_zc     = zc_vec[zero_cross_src];
   wire [OC_W-1:0] next_oc     = overcurrent_raw & overcurrent_enables;

   // routing stage; a source change may give one spurious tick, accepted for simplicity
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         selected_line_period <= '0;
         shared_pulse_zc_pin  <= 1'b0;
         line_cycle_tick      <= 1'b0;
         overcurrent_flags    <= '0;
      end else if (ce) begin
         selected_line_period <= next_period;
         shared_pulse_zc_pin  <= next_zc;
         line_cycle_tick      <= next_zc && !shared_pulse_zc_pin;
         overcurrent_flags    <= next_oc;
      end
   end

   a_read_unmapped: assert property (@(posedge clk) disable iff (!rst_n)
      ce && rd_en && !hit_any |=> rdata == '0)
      else $error("unmapped read returned nonzero data");
   a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
      ce && rd_en && hit_ocpk |=> rdata[OC_LSB-1:PEAK_LSB+PEAK_W] == '0 && rdata[PEAK_LSB-1:0] == '0)
      else $error("reserved bits read nonzero");
   a_wiring_write: assert property (@(posedge clk) disable iff (!rst_n)
      wr_acc ##1 ce && rd_en && hit_acc |=> rdata[WIRING_LSB +: WIRING_W] == $past(wdata[WIRING_LSB +: WIRING_W], 2))
      else $error("wiring code did not read back");
   a_oc_reset: assert property (@(posedge clk)
      $rose(rst_n) |-> overcurrent_enables == OVERCURRENT_ENABLES_RST && line_period_src == LP_RST && zero_cross_src == ZC_RST)
      else $error("reset values wrong after release");
   a_oc_gate: assert property (@(posedge clk) disable iff (!rst_n)
      ce && overcurrent_raw[0] && !overcurrent_enables[0] |=> !overcurrent_flags[0])
      else $error("disabled phase a overcurrent flagged");
   a_peak_write: assert property (@(posedge clk) disable iff (!rst_n)
      wr_ocpk |=> peak_phase_sel == $past(wdata[PEAK_LSB +: PEAK_W]))
      else $error("peak selection not stored");
   a_lp_route: assert property (@(posedge clk) disable iff (!rst_n)
      ce && line_period_src == LP_RST |=> selected_line_period == $past(combined_line_period))
      else $error("combined line period not routed");
   a_zc_route: assert property (@(posedge clk) disable iff (!rst_n)
      ce && zero_cross_src == 2'h0 ##1 ce && zero_cross_src == 2'h0
      |=> line_cycle_tick == ($past(phase_a_zero_cross) && !$past(phase_a_zero_cross, 2)))
      else $error("phase a zero crossing not routed");
endmodule

/* File: design/mcf_pkg.sv */
// register offsets, field layout, reset values and mode codes of the metering config bank
// What this block does
// - wiring code zero passes phase voltages unchanged
// - code one: phase B becomes A minus C
// - code two: phase B becomes minus A minus C
// - code three: phase B becomes minus A
// - code four: A-B, A-C, C-B on three phases
// - reactive field: signed, absolute, positive, negative accumulation
// - active field: same four accumulation modes
// - four overcurrent enables, reset to all ones
// - bits 12..15 pick A, B, C, neutral
// - peak field bits enable phases A, B, C
// - line period source select, reset combined
// - zero-cross source drives pin, reset combined
package mcf_pkg;

   // register port geometry
   localparam int unsigned ADDR_W            = 12;
   localparam int unsigned DATA_W            = 16;

   // register offsets
   localparam logic [ADDR_W-1:0] ACCUM_WIRING_OFS = 12'h492;
   localparam logic [ADDR_W-1:0] OC_PEAK_OFS      = 12'h493;
   localparam logic [ADDR_W-1:0] PERIOD_ZC_OFS    = 12'h49A;
   localparam logic [ADDR_W-1:0] STATUS_OFS       = 12'h49F;

   // field positions and widths
   localparam int unsigned WIRING_LSB        = 4;
   localparam int unsigned WIRING_W          = 3;
   localparam int unsigned REACT_LSB         = 2;
   localparam int unsigned ACTIVE_LSB        = 0;
   localparam int unsigned ACCUM_W           = 2;
   localparam int unsigned OC_LSB            = 12;
   localparam int unsigned OC_W              = 4;
   localparam int unsigned PEAK_LSB          = 2;
   localparam int unsigned PEAK_W            = 3;
   localparam int unsigned LP_LSB            = 3;
   localparam int unsigned ZC_LSB            = 1;
   localparam int unsigned SRC_W             = 2;
   localparam int unsigned STATUS_OC_LSB     = 0;
   localparam int unsigned STATUS_ZC_BIT     = 4;

   // field reset values
   localparam logic [WIRING_W-1:0] WIRING_RST = 3'h0;
   localparam logic [ACCUM_W-1:0]  ACCUM_RST  = 2'h0;
   localparam logic [OC_W-1:0]     OVERCURRENT_ENABLES_RST  = 4'hF;
   localparam logic [PEAK_W-1:0]   PEAK_RST   = 3'h0;
   localparam logic [SRC_W-1:0]    LP_RST     = 2'h3;
   localparam logic [SRC_W-1:0]    ZC_RST     = 2'h3;

   // wiring arrangements; codes five to seven behave as code zero
   typedef enum logic [2:0] {
      MCF_WYE_4W       = 3'h0,
      MCF_DELTA_3W     = 3'h1,
      MCF_WYE_NB       = 3'h2,
      MCF_DELTA_NB     = 3'h3,
      MCF_DELTA_3W_ALL = 3'h4
   } mcf_wiring_e;

   // accumulation modes for energy and pulse paths
   typedef enum logic [1:0] {
      MCF_ACC_SIGNED = 2'h0,
      MCF_ACC_ABS    = 2'h1,
      MCF_ACC_POS    = 2'h2,
      MCF_ACC_NEG    = 2'h3
   } mcf_accum_e;

endpackage

/* File: design/mcf_wiring_map.sv */
// voltage derivation for the selected wiring arrangement
`timescale 1ns/1ns
module mcf_wiring_map #(
   parameter int VW = 24
) (
   // clock, reset, enable
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  wire logic                ce,
   // live configuration
   mcf_cfg_if.user                  cfg,
   // measured phase voltages
   input  wire logic signed [VW-1:0] va,
   input  wire logic signed [VW-1:0] vb,
   input  wire logic signed [VW-1:0] vc,
   // derived phase voltages, two bits of headroom
   output logic signed [VW+1:0]     va_out,
   output logic signed [VW+1:0]     vb_out,
   output logic signed [VW+1:0]     vc_out
);
   import mcf_pkg::*;
   localparam int OW = VW + 2;

   // two guard bits so that the negated sum can never wrap
   wire signed [OW-1:0] xa         = OW'(va);
   wire signed [OW-1:0] xb         = OW'(vb);
   wire signed [OW-1:0] xc         = OW'(vc);
   wire signed [OW-1:0] diff_ac    = xa - xc;
   wire signed [OW-1:0] diff_ab    = xa - xb;
   wire signed [OW-1:0] diff_cb    = xc - xb;
   wire signed [OW-1:0] neg_sum_ac = -xa - xc;
   wire signed [OW-1:0] neg_a      = -xa;
   wire                 sel_full   = cfg.wiring_config_sel == MCF_DELTA_3W_ALL;

   // selection of each derived voltage
   wire signed [OW-1:0] next_va = sel_full ? diff_ab : xa;
   wire signed [OW-1:0] next_vb =
      (cfg.wiring_config_sel == MCF_DELTA_3W) ? diff_ac :
      (cfg.wiring_config_sel == MCF_WYE_NB)   ? neg_sum_ac :
      (cfg.wiring_config_sel == MCF_DELTA_NB) ? neg_a :
      sel_full                                ? diff_ac :
      xb;
   wire signed [OW-1:0] next_vc = sel_full ? diff_cb : xc;

   // one register stage, frozen while ce is low
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         va_out <= '0;
         vb_out <= '0;
         vc_out <= '0;
      end else if (ce) begin
         va_out <= next_va;
         vb_out <= next_vb;
         vc_out <= next_vc;
      end
   end

   a_wye_pass: assert property (@(posedge clk) disable iff (!rst_n)
      ce && cfg.wiring_config_sel == MCF_WYE_4W |=> va_out == $past(xa) && vb_out == $past(xb) && vc_out == $past(xc))
      else $error("wye mode altered a phase voltage");
   a_delta_b: assert property (@(posedge clk) disable iff (!rst_n)
      ce && cfg.wiring_config_sel == MCF_DELTA_3W |=> vb_out == $past(xa - xc) && va_out == $past(xa))
      else $error("delta phase b not a minus c");
   a_nb_wye: assert property (@(posedge clk) disable iff (!rst_n)
      ce && cfg.wiring_config_sel == MCF_WYE_NB |=> vb_out == $past(-xa - xc))
      else $error("non-blondel wye phase b wrong");
   a_nb_delta: assert property (@(posedge clk) disable iff (!rst_n)
      ce && cfg.wiring_config_sel == MCF_DELTA_NB |=> vb_out == $past(-xa))
      else $error("non-blondel delta phase b wrong");
   a_delta_full: assert property (@(posedge clk) disable iff (!rst_n)
      ce && sel_full |=> va_out == $past(xa - xb) && vb_out == $past(xa - xc) && vc_out == $past(xc - xb))
      else $error("full delta derivation wrong");
endmodule

/* File: sim/mcf_host_model.sv */
// host-side register master for the metering config bank
`timescale 1ns/1ns
module mcf_host_model (
   // clock
   input  wire logic                       clk,
   // register port, driven right after each rising edge
   output logic      [mcf_pkg::ADDR_W-1:0] addr,
   output logic      [mcf_pkg::DATA_W-1:0] wdata,
   output logic                            wr_en,
   output logic                            rd_en,
   input  wire logic [mcf_pkg::DATA_W-1:0] rdata
);
   import mcf_pkg::*;
   // idle bus from time zero
   initial begin
      addr = '0;
      wdata = '0;
      wr_en = 1'b0;
      rd_en = 1'b0;
   end
   // one-cycle write strobe
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
   // read data only stand in the cycle after the strobe
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 v = rdata;
   endtask
endmodule

/* File: sim/tb_metering_config_fields.sv */
// self-checking bench for the metering configuration register bank
`timescale 1ns/1ns
module tb_metering_config_fields;
   import mcf_pkg::*;
   // clock, reset, register port
   logic               clk, rst_n, ce, wr_en, rd_en;
   logic [ADDR_W-1:0]  addr;
   logic [DATA_W-1:0]  wdata, rdata, d, w0, w1, w2;
   // datapath stimulus and results
   logic signed [23:0] phase_a_voltage, phase_b_voltage, phase_c_voltage;
   logic signed [25:0] phase_a_derived, phase_b_derived, phase_c_derived;
   logic signed [31:0] active_total, active_fund, reactive_total, reactive_fund;
   logic signed [32:0] active_total_acc, active_fund_acc, reactive_total_acc, reactive_fund_acc;
   logic [3:0]         overcurrent_raw, overcurrent_flags, zc;
   logic [2:0]         peak_phase_sel;
   logic [31:0]        lp [4];
   logic [31:0]        selected_line_period;
   logic               shared_pulse_zc_pin, line_cycle_tick, pz;
   int                 failures = 0;
   int                 total_checks = 0;

   mcf_metering_config u_dut (.clk, .rst_n, .ce, .addr, .wdata, .wr_en, .rd_en, .rdata,
      .phase_a_voltage, .phase_b_voltage, .phase_c_voltage, .phase_a_derived, .phase_b_derived,
      .phase_c_derived, .active_total, .active_fund, .reactive_total, .reactive_fund, .active_total_acc,
      .active_fund_acc, .reactive_total_acc, .reactive_fund_acc, .overcurrent_raw, .overcurrent_flags,
      .peak_phase_sel, .phase_a_line_period(lp[0]), .phase_b_line_period(lp[1]), .phase_c_line_period(lp[2]),
      .combined_line_period(lp[3]), .selected_line_period, .phase_a_zero_cross(zc[0]),
      .phase_b_zero_cross(zc[1]), .phase_c_zero_cross(zc[2]), .combined_zero_cross(zc[3]),
      .shared_pulse_zc_pin, .line_cycle_tick);
   mcf_host_model u_host (.clk, .addr, .wdata, .wr_en, .rd_en, .rdata);

   // free-running 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // compare and count
   task automatic check(input string n, input logic [63:0] s, input logic [63:0] e);
      total_checks++;
      if (s !== e) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", n, e, s);
      end
   endtask
   // expected derived voltage of phase k under wiring code m
   function automatic logic signed [25:0] wx(int k, logic [2:0] m);
      logic signed [25:0] a, b, c;
      a = phase_a_voltage;
      b = phase_b_voltage;
      c = phase_c_voltage;
      case (m)
         3'h1: b = a - c;
         3'h2: b = -a - c;
         3'h3: b = -a;
         3'h4: begin
            b = a - c;
            c = c - phase_b_voltage;
            a = a - phase_b_voltage;
         end
         default: ;
      endcase
      return k == 0 ? a : (k == 1 ? b : c);
   endfunction
   // expected sample after accumulation mode m
   function automatic logic signed [32:0] ax(logic [1:0] m, logic signed [31:0] v);
      logic signed [32:0] x;
      x = v;
      if ((m == 2'h1 || m == 2'h3) && x > 0 && m == 2'h3) x = '0;
      else if (x < 0 && m == 2'h1) x = -x;
      else if (x < 0 && m == 2'h2) x = '0;
      return x;
   endfunction
   // random datapath inputs, all at one edge
   task automatic stim();
      {phase_a_voltage, phase_b_voltage, phase_c_voltage} <= 72'({$urandom, $urandom, $urandom});
      {active_total, active_fund, reactive_total, reactive_fund} <= {$urandom, $urandom, $urandom, $urandom};
      foreach (lp[k]) lp[k] <= $urandom;
      zc <= 4'($urandom);
      overcurrent_raw <= 4'($urandom);
   endtask
   // closing verdict
   task automatic final_report();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // hang guard, far beyond the expected seven hundred or so cycles
   initial begin
      #100000;
      failures++;
      final_report();
   end
   // reset images, then randomised configuration sweeps
   initial begin
      void'($urandom(32'h12DFBDD3));
      rst_n = 1'b0;
      ce = 1'b1;
      stim();
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      u_host.rd(ACCUM_WIRING_OFS, d); check("accum_wiring", d, 16'h0000);
      u_host.rd(OC_PEAK_OFS, d); check("oc_peak", d, 16'hF000);
      u_host.rd(PERIOD_ZC_OFS, d); check("period_zc", d, 16'h001E);
      u_host.rd(12'h7FF, d); check("unmapped", d, 16'h0000);
      // pin level before the first source change, combined source after reset
      pz = zc[3];
      for (int i = 0; i < 40; i++) begin
         {w0, w1, w2} = 48'({$urandom, $urandom});
         w0[6:4] = 3'(i % 8);
         w0[3:0] = 4'(i % 16);
         if (i == 0) {w1, w2} = 32'hFFFFFFFF;
         u_host.wr(ACCUM_WIRING_OFS, w0);
         u_host.wr(OC_PEAK_OFS, w1);
         u_host.wr(PERIOD_ZC_OFS, w2);
         stim();
         @(posedge clk);
         #1 check("tick", line_cycle_tick, zc[w2[2:1]] && !pz);
         @(posedge clk);
         #1;
         check("va", phase_a_derived, wx(0, w0[6:4]));
         check("vb", phase_b_derived, wx(1, w0[6:4]));
         check("vc", phase_c_derived, wx(2, w0[6:4]));
         check("act_tot", active_total_acc, ax(w0[1:0], active_total));
         check("act_fund", active_fund_acc, ax(w0[1:0], active_fund));
         check("react_tot", reactive_total_acc, ax(w0[3:2], reactive_total));
         check("react_fund", reactive_fund_acc, ax(w0[3:2], reactive_fund));
         check("oc", overcurrent_flags, overcurrent_raw & w1[15:12]);
         check("peak", peak_phase_sel, w1[4:2]);
         check("lp", selected_line_period, lp[w2[4:3]]);
         check("zc", shared_pulse_zc_pin, zc[w2[2:1]]);
         pz = zc[w2[2:1]];
         u_host.rd(ACCUM_WIRING_OFS, d); check("rb0", d, w0 & 16'h007F);
         u_host.rd(OC_PEAK_OFS, d); check("rb1", d, w1 & 16'hF01C);
         u_host.rd(PERIOD_ZC_OFS, d); check("rb2", d, w2 & 16'h001E);
         u_host.rd(STATUS_OFS, d);
         check("status", d, {11'h000, zc[w2[2:1]], overcurrent_raw & w1[15:12]});
         // read data must fall back to zero one cycle later
         @(posedge clk);
         #1 check("rd_clear", rdata, 16'h0000);
      end
      // a write while ce is low must leave the fields alone
      ce <= 1'b0;
      u_host.wr(ACCUM_WIRING_OFS, 16'h0000);
      ce <= 1'b1;
      u_host.rd(ACCUM_WIRING_OFS, d); check("ce_hold", d, w0 & 16'h007F);
      // second reset in mid-run brings the defaults back
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      u_host.rd(OC_PEAK_OFS, d); check("oc_rst", d, 16'hF000);
      u_host.rd(PERIOD_ZC_OFS, d); check("pzc_rst", d, 16'h001E);
      final_report();
   end
endmodule
